// ===== shared/frs_pkg.sv
// Package for the field reversal sequencer: register map, fields, timing
// -----------------------------------------------------------------------
// What this block does
// - Sequence reversing contactors to invert field polarity
// - Wait low field current, delay one, open contactor
// - Delay two, then close opposite contactor
// - Delay three, then enable field firing pulses
// - Field above setpoint fraction, delay four, armature enable
// - Four delays programmable 0.0 to 10.0 s, 0.1 s steps
// -----------------------------------------------------------------------
package frs_pkg;
  // Bus
  localparam int unsigned frs_addr_w = 8;
  localparam logic [7:0] frs_ctrl_off = 8'h00;
  localparam logic [7:0] frs_status_off = 8'h04;
  localparam logic [7:0] frs_delay0_off = 8'h08;
  localparam logic [7:0] frs_delay1_off = 8'h0C;
  localparam logic [7:0] frs_delay2_off = 8'h10;
  localparam logic [7:0] frs_delay3_off = 8'h14;
  localparam logic [7:0] frs_imin_off = 8'h18;
  localparam logic [7:0] frs_ithr_pct_off = 8'h1C;
  // Control fields
  localparam int unsigned frs_ctrl_req_bit = 0;
  localparam int unsigned frs_ctrl_dir_bit = 1;
  // Status fields
  localparam int unsigned frs_stat_dir_bit = 0;
  localparam int unsigned frs_stat_busy_bit = 1;
  localparam int unsigned frs_stat_fwd_bit = 2;
  localparam int unsigned frs_stat_rev_bit = 3;
  localparam int unsigned frs_stat_fpe_bit = 4;
  localparam int unsigned frs_stat_arm_bit = 5;
  localparam int unsigned frs_stat_state_lsb = 8;
  // Widths
  localparam int unsigned frs_delay_w = 7;
  localparam int unsigned frs_cur_w = 16;
  localparam int unsigned frs_pct_w = 8;
  // Delay limits and defaults in 0.1 s steps, then current and percent defaults
  localparam logic [6:0] frs_delay_max = 7'd100;
  localparam logic [6:0] frs_delay0_rst = 7'd30;
  localparam logic [6:0] frs_delay1_rst = 7'd2;
  localparam logic [6:0] frs_delay2_rst = 7'd1;
  localparam logic [6:0] frs_delay3_rst = 7'd30;
  localparam logic [15:0] frs_imin_rst = 16'h0000;
  localparam logic [7:0] frs_ithr_pct_rst = 8'h00;
  localparam int unsigned frs_pct_full = 100;
  // Timebase
  localparam int unsigned frs_clk_hz = 20_000_000;
  localparam int unsigned frs_tick_ms = 100;
  localparam int unsigned frs_tick_cycles = frs_clk_hz / 1000 * frs_tick_ms;
  typedef enum logic [2:0] {
    frs_idle, frs_wait_low, frs_delay_open, frs_delay_close, frs_delay_fire,
    frs_wait_build, frs_delay_arm, frs_running
  } frs_state_type;
endpackage : frs_pkg

// ===== verilog/frs_tick.sv
// Tenth-second timebase for the field reversal sequencer
`timescale 1ns/10ps
`default_nettype none
module frs_tick #(
  parameter int unsigned tick_cycles = frs_pkg::frs_tick_cycles
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  output logic tick_o
);
  localparam logic [21:0] last_count = 22'(tick_cycles - 1);
  logic [21:0] count_reg;
  logic wrap;
  assign wrap = (count_reg == last_count);
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      count_reg <= '0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      count_reg <= wrap ? '0 : count_reg + 22'd1;
      tick_o <= wrap;
    end
  end
endmodule : frs_tick
`default_nettype wire

// ===== verilog/frs_sequencer.sv
// Field reversal sequencer with APB register slave
`timescale 1ns/10ps
`default_nettype none
module frs_sequencer #(
  parameter int unsigned tick_cycles = frs_pkg::frs_tick_cycles
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [frs_pkg::frs_addr_w-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [frs_pkg::frs_cur_w-1:0] field_current_actual_i,
  input wire logic [frs_pkg::frs_cur_w-1:0] field_current_setpoint_i,
  output logic contactor_fwd_o,
  output logic contactor_rev_o,
  output logic field_pulse_enable_o,
  output logic armature_enable_o
);
  import frs_pkg::*;

  // -----------------------------------------------------------
  // Register bus
  // -----------------------------------------------------------
  logic [frs_delay_w-1:0] field_reversal_delay_set_reg [4];
  logic [frs_cur_w-1:0] field_current_minimum_reg;
  logic [frs_pct_w-1:0] field_buildup_threshold_pct_reg;
  logic dir_target_reg;
  logic req_reg;
  frs_state_type state_reg;
  logic dir_reg;
  logic [frs_delay_w-1:0] delay_count_reg;
  logic tick;

  wire access = psel_i && penable_i && !pready_o;
  wire wr = access && pwrite_i;
  wire [5:0] word_idx = paddr_i[7:2];
  wire aligned = (paddr_i[1:0] == 2'b00);
  wire hit_ctrl = aligned && (paddr_i == frs_ctrl_off);
  wire hit_status = aligned && (paddr_i == frs_status_off);
  wire hit_delay = aligned && (paddr_i >= frs_delay0_off) && (paddr_i <= frs_delay3_off);
  wire hit_imin = aligned && (paddr_i == frs_imin_off);
  wire hit_pct = aligned && (paddr_i == frs_ithr_pct_off);
  wire mapped = hit_ctrl || hit_status || hit_delay || hit_imin || hit_pct;
  wire [1:0] delay_sel = 2'(word_idx - 6'(frs_delay0_off >> 2));
  // Out-of-range delays clamp so no single delay can run past 10 s
  wire [frs_delay_w-1:0] delay_wr =
    (pwdata_i > 32'(frs_delay_max)) ? frs_delay_max : pwdata_i[6:0];
  wire start_req = wr && hit_ctrl && pwdata_i[frs_ctrl_req_bit];
  wire busy = (state_reg != frs_idle) && (state_reg != frs_running);

  // -----------------------------------------------------------
  // Read data
  // -----------------------------------------------------------
  wire [31:0] status_word = {16'h0000, 5'b0_0000, 3'(state_reg), 2'b00,
    armature_enable_o, field_pulse_enable_o, contactor_rev_o, contactor_fwd_o,
    busy, dir_reg};
  wire [31:0] rd_data =
    hit_ctrl ? {30'h0000_0000, dir_target_reg, req_reg} :
    hit_status ? status_word :
    hit_delay ? {25'h000_0000, field_reversal_delay_set_reg[delay_sel]} :
    hit_imin ? {16'h0000, field_current_minimum_reg} :
    hit_pct ? {24'h00_0000, field_buildup_threshold_pct_reg} : 32'h0000_0000;

  // -----------------------------------------------------------
  // Bus answer
  // -----------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      pready_o <= access;
      pslverr_o <= access && !mapped;
      if (access && !pwrite_i) begin
        prdata_o <= rd_data;
      end
    end
  end

  // -----------------------------------------------------------
  // Register writes
  // -----------------------------------------------------------
  localparam logic [frs_delay_w-1:0] delay_rst [4] =
    '{frs_delay0_rst, frs_delay1_rst, frs_delay2_rst, frs_delay3_rst};
  for (genvar i = 0; i < 4; i++) begin : g_delay
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        field_reversal_delay_set_reg[i] <= delay_rst[i];
      end else if (ce_i && wr && hit_delay && delay_sel == 2'(i)) begin
        field_reversal_delay_set_reg[i] <= delay_wr;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      field_current_minimum_reg <= frs_imin_rst;
      field_buildup_threshold_pct_reg <= frs_ithr_pct_rst;
      dir_target_reg <= 1'b0;
    end else if (ce_i && wr) begin
      if (hit_imin) begin
        field_current_minimum_reg <= pwdata_i[15:0];
      end
      if (hit_pct) begin
        field_buildup_threshold_pct_reg <= pwdata_i[7:0];
      end
      if (hit_ctrl) begin
        dir_target_reg <= pwdata_i[frs_ctrl_dir_bit];
      end
    end
  end

  // -----------------------------------------------------------
  // Timebase
  // -----------------------------------------------------------
  frs_tick #(
    .tick_cycles(tick_cycles)
  ) u_tick (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .tick_o(tick)
  );

  // -----------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------
  // Threshold compare kept in integer form: actual*100 > setpoint*pct
  wire [23:0] act_scaled = 24'(field_current_actual_i) * 24'(frs_pct_full);
  wire [23:0] set_scaled = 24'(field_current_setpoint_i) * 24'(field_buildup_threshold_pct_reg);
  wire field_low = field_current_actual_i < field_current_minimum_reg;
  wire field_built = act_scaled > set_scaled;
  wire delay_done = (delay_count_reg == '0);
  wire [frs_delay_w-1:0] delay_dec = tick ? delay_count_reg - 7'd1 : delay_count_reg;

  // -----------------------------------------------------------
  // State machine
  // -----------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= frs_idle;
      dir_reg <= 1'b0;
      req_reg <= 1'b0;
      delay_count_reg <= '0;
      contactor_fwd_o <= 1'b0;
      contactor_rev_o <= 1'b0;
      field_pulse_enable_o <= 1'b0;
      armature_enable_o <= 1'b0;
    end else if (ce_i) begin
      if (start_req) begin
        req_reg <= 1'b1;
      end else if (state_reg == frs_wait_low) begin
        req_reg <= 1'b0;
      end
      unique case (state_reg)
        frs_idle, frs_running: begin
          // A request with no change of direction is ignored
          if (req_reg && dir_target_reg != dir_reg) begin
            state_reg <= frs_wait_low;
            armature_enable_o <= 1'b0;
            field_pulse_enable_o <= 1'b0;
          end else if (!start_req) begin
            // A fresh write in this cycle must not be lost
            req_reg <= 1'b0;
          end
        end
        frs_wait_low: begin
          if (field_low) begin
            delay_count_reg <= field_reversal_delay_set_reg[0];
            state_reg <= frs_delay_open;
          end
        end
        frs_delay_open: begin
          delay_count_reg <= delay_dec;
          if (delay_done) begin
            contactor_fwd_o <= 1'b0;
            contactor_rev_o <= 1'b0;
            delay_count_reg <= field_reversal_delay_set_reg[1];
            state_reg <= frs_delay_close;
          end
        end
        frs_delay_close: begin
          delay_count_reg <= delay_dec;
          if (delay_done) begin
            contactor_fwd_o <= !dir_target_reg;
            contactor_rev_o <= dir_target_reg;
            dir_reg <= dir_target_reg;
            delay_count_reg <= field_reversal_delay_set_reg[2];
            state_reg <= frs_delay_fire;
          end
        end
        frs_delay_fire: begin
          delay_count_reg <= delay_dec;
          if (delay_done) begin
            field_pulse_enable_o <= 1'b1;
            state_reg <= frs_wait_build;
          end
        end
        frs_wait_build: begin
          if (field_built) begin
            delay_count_reg <= field_reversal_delay_set_reg[3];
            state_reg <= frs_delay_arm;
          end
        end
        frs_delay_arm: begin
          delay_count_reg <= delay_dec;
          if (delay_done) begin
            armature_enable_o <= 1'b1;
            state_reg <= frs_running;
          end
        end
      endcase
    end
  end
endmodule : frs_sequencer
`default_nettype wire

// ===== bench/frs_seq_monitor.sv
// Port checks for the field reversal sequencer
`timescale 1ns/10ps
`default_nettype none
module frs_seq_monitor (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic contactor_fwd_o,
  input wire logic contactor_rev_o,
  input wire logic field_pulse_enable_o,
  input wire logic armature_enable_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_taken;
    psel_i && penable_i && !pready_o && ce_i;
  endsequence
  sequence s_answer;
    pready_o ##1 !pready_o;
  endsequence
  a_apb_one_wait: assert property (s_taken |=> s_answer)
    else $error("apb answer late");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_contactor_excl: assert property (!(contactor_fwd_o && contactor_rev_o))
    else $error("both contactors on");
  a_open_before_close: assert property ($rose(contactor_fwd_o) || $rose(contactor_rev_o)
    |-> !$past(contactor_fwd_o) && !$past(contactor_rev_o)) else $error("no open gap");
  a_fire_after_close: assert property ($rose(field_pulse_enable_o)
    |-> $past(contactor_fwd_o) || $past(contactor_rev_o)) else $error("fired too soon");
  a_fire_holds_path: assert property (field_pulse_enable_o |-> contactor_fwd_o || contactor_rev_o)
    else $error("firing without contactor");
  a_arm_after_fire: assert property ($rose(armature_enable_o) |-> $past(field_pulse_enable_o))
    else $error("armature before field");
  a_arm_needs_fire: assert property (armature_enable_o |-> field_pulse_enable_o)
    else $error("armature without field");
  a_reset_idle: assert property (@(posedge mclk_i) disable iff (1'b0) rst_i |=>
    !contactor_fwd_o && !contactor_rev_o && !field_pulse_enable_o && !armature_enable_o)
    else $error("reset not idle");
endmodule : frs_seq_monitor
bind frs_sequencer frs_seq_monitor u_frs_seq_monitor (.mclk_i(mclk_i), .rst_i(rst_i),
  .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .contactor_fwd_o(contactor_fwd_o), .contactor_rev_o(contactor_rev_o),
  .field_pulse_enable_o(field_pulse_enable_o), .armature_enable_o(armature_enable_o));
`default_nettype wire

// ===== bench/frs_field_model.sv
// Field supply model: contactors and firing pulses shape the field current
`timescale 1ns/10ps
`default_nettype none
module frs_field_model (
  input wire logic mclk_i,
  input wire logic contactor_fwd_i,
  input wire logic contactor_rev_i,
  input wire logic field_pulse_enable_i,
  output logic [15:0] current_o
);
  initial current_o = 16'h0000;
  // Open contactors cut the field at once; the slow decay stresses the low wait
  always @(posedge mclk_i) begin
    if (!contactor_fwd_i && !contactor_rev_i) begin
      current_o <= 16'h0000;
    end else if (field_pulse_enable_i) begin
      current_o <= (current_o > 16'h07C0) ? 16'h0800 : current_o + 16'h0040;
    end else begin
      current_o <= (current_o < 16'h0040) ? 16'h0000 : current_o - 16'h0040;
    end
  end
endmodule : frs_field_model
`default_nettype wire

// ===== bench/test_frs_sequencer.sv
// Self-checking bench for the field reversal sequencer
`timescale 1ns/10ps
`default_nettype none
module test_frs_sequencer;
  import frs_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] prd, rdat;
  logic prdy, perr, err, fwd, rev, fpe, arm;
  logic [15:0] cur;
  logic [15:0] fset = 16'h0400;
  wire [3:0] outs = {arm, fpe, rev, fwd};
  int bad_count = 0;
  int cmp_count = 0;
  int n;
  initial forever #25 mclk_i = ~mclk_i;
  frs_sequencer #(.tick_cycles(10)) u_frs_sequencer (.mclk_i(mclk_i), .rst_i(rst_i),
    .ce_i(1'b1), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr),
    .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .field_current_actual_i(cur), .field_current_setpoint_i(fset),
    .contactor_fwd_o(fwd), .contactor_rev_o(rev), .field_pulse_enable_o(fpe),
    .armature_enable_o(arm));
  frs_field_model u_frs_field_model (.mclk_i(mclk_i), .contactor_fwd_i(fwd),
    .contactor_rev_i(rev), .field_pulse_enable_i(fpe), .current_o(cur));
  // ----------
  // Tasks
  // ----------
  task finish_test;
    $display("checks=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Entered just after a rising edge; idles one edge so calls may follow
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge mclk_i);
    pen <= 1'b1;
    do @(posedge mclk_i); while (prdy !== 1'b1);
    rdat = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge mclk_i);
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask : rd
  // Negedges from the first one until an output is seen high, against a window
  task wt(input int b, input int lo, input int hi);
    n = 0;
    @(negedge mclk_i);
    while (outs[b] !== 1'b1 && n < 500) begin
      @(negedge mclk_i);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h0000_0001);
    @(posedge mclk_i);
  endtask : wt
  // ----------
  // Tests
  // ----------
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    rd(frs_delay0_off, 32'h0000_001E);
    rd(frs_delay1_off, 32'h0000_0002);
    rd(frs_delay2_off, 32'h0000_0001);
    rd(frs_delay3_off, 32'h0000_001E);
    rd(frs_status_off, 32'h0000_0000);
    apb(1'b1, frs_delay1_off, 32'h0000_0065);
    rd(frs_delay1_off, 32'h0000_0064);
    apb(1'b1, frs_delay1_off, 32'h0000_00C8);
    rd(frs_delay1_off, 32'h0000_0064);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    chk(rdat, 32'h0000_0000);
    apb(1'b1, frs_delay0_off, 32'h0000_0002);
    apb(1'b1, frs_delay1_off, 32'h0000_0001);
    apb(1'b1, frs_delay2_off, 32'h0000_0000);
    apb(1'b1, frs_delay3_off, 32'h0000_0003);
    apb(1'b1, frs_imin_off, 32'h0000_0010);
    apb(1'b1, frs_ithr_pct_off, 32'h0000_0032);
    apb(1'b1, frs_ctrl_off, 32'h0000_0003);
    wt(1, 22, 31);
    wt(2, 0, 1);
    wt(3, 31, 40);
    rd(frs_status_off, 32'h0000_0739);
    // Lower setpoint must shorten the build-up wait of the next reversal
    fset <= 16'h0200;
    apb(1'b1, frs_ctrl_off, 32'h0000_0001);
    chk(32'(outs), 32'h0000_0002);
    wt(0, 54, 63);
    wt(2, 0, 1);
    wt(3, 27, 36);
    apb(1'b1, frs_ctrl_off, 32'h0000_0001);
    rd(frs_status_off, 32'h0000_0734);
    // Reset in mid-reversal drops every drive and restores defaults
    apb(1'b1, frs_ctrl_off, 32'h0000_0003);
    repeat (40) @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    chk(32'(outs), 32'h0000_0000);
    rd(frs_status_off, 32'h0000_0000);
    rd(frs_delay0_off, 32'h0000_001E);
    finish_test();
  end
  initial begin
    repeat (3000) @(posedge mclk_i);
    bad_count++;
    finish_test();
  end
endmodule : test_frs_sequencer
`default_nettype wire
